// ### pkg/asbc_consts.vh
// Constants for the acceleration sample buffer control block.
`ifndef ASBC_CONSTS_VH
`define ASBC_CONSTS_VH
// Register indices; the byte address is four times the index.
`define ASBC_IDX_CONFIG1 6'h26
`define ASBC_IDX_CONFIG2 6'h27
`define ASBC_IDX_CTRL 6'h28
`define ASBC_IDX_STATUS 6'h29
`define ASBC_IDX_DATA_XY 6'h2A
`define ASBC_IDX_DATA_Z 6'h2B
`define ASBC_IDX_IRQ_STAT 6'h2C
`define ASBC_IDX_IRQ_EN 6'h2D
`define ASBC_IDX_IRQ_CLR 6'h2E
// Collection configuration fields.
`define ASBC_CFG_RESET 8'h00
`define ASBC_CFG_ORDER 7
`define ASBC_CFG_MODE_HI 6
`define ASBC_CFG_MODE_LO 5
`define ASBC_CFG_GATE 4
`define ASBC_CFG_TRIG_WB 3
`define ASBC_CFG_TRIG_OB 2
`define ASBC_CFG_TRIG_TILT 0
// Collection modes.
`define ASBC_MODE_OFF 2'h0
`define ASBC_MODE_STREAM 2'h1
`define ASBC_MODE_STOP 2'h2
`define ASBC_MODE_TRIG 2'h3
// Second configuration: watermark and flush strobe.
`define ASBC_WMRK_HI 5
`define ASBC_FLUSH_BIT 7
// Control: sensor active, second pin function, sleep delay count.
`define ASBC_CTRL_ACTIVE 0
`define ASBC_CTRL_PIN2 1
`define ASBC_CTRL_SLP_HI 15
`define ASBC_CTRL_SLP_LO 8
// Status fields.
`define ASBC_ST_OVF 6
`define ASBC_ST_GERR 7
`define ASBC_ST_TRIG 8
`define ASBC_ST_GCNT_LO 16
// Interrupt event bits.
`define ASBC_IRQ_OVF 0
`define ASBC_IRQ_GERR 1
`define ASBC_IRQ_TRIG 2
`define ASBC_IRQ_W 3
// Buffer geometry.
`define ASBC_DEPTH 6'h20
`define ASBC_SAMPLE_W 36
`endif

// ### design/asbc_sample_mem.v
// Sample storage array of the acceleration buffer.
`timescale 1ns/1ps
`include "asbc_consts.vh"
module asbc_sample_mem (
  // Clock.
  input wire core_clk,
  // Write side.
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [`ASBC_SAMPLE_W-1:0] wr_data,
  // Read side.
  input wire [4:0] rd_addr,
  output wire [`ASBC_SAMPLE_W-1:0] rd_data
);
  reg [`ASBC_SAMPLE_W-1:0] mem [0:31];

  // Store one sample per accepted write; storage needs no reset.
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read is combinational so the bus sees the current head sample.
  assign rd_data = mem[rd_addr];
endmodule // asbc_sample_mem

// ### design/asbc_trig_sel.v
// Trigger source selection for triggered capture.
`timescale 1ns/1ps
`include "asbc_consts.vh"
module asbc_trig_sel (
  // Configuration.
  input wire [7:0] cfg,
  // Detector event pulses.
  input wire evt_within_band,
  input wire evt_outside_band,
  input wire evt_tilt_change,
  // Combined trigger.
  output wire trig_hit
);
  assign trig_hit = (cfg[`ASBC_CFG_TRIG_WB] & evt_within_band) |
                    (cfg[`ASBC_CFG_TRIG_OB] & evt_outside_band) |
                    (cfg[`ASBC_CFG_TRIG_TILT] & evt_tilt_change);
endmodule // asbc_trig_sel

// ### design/asbc_top.v
// Acceleration sample buffer control with APB register access.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "asbc_consts.vh"
// Behaviour
// - With the order bit clear, samples are read oldest first.
// - With the order bit set, samples are read newest first.
// - Collection configuration writes are ignored while the active or second pin function bit is set.
// - Mode 00 disables the buffer and stores no samples.
// - Stream mode drops the oldest entry when a sample arrives while full.
// - Stop mode rejects samples once full and keeps the contents.
// - Trigger mode runs circularly before a trigger, holding at most watermark samples.
// - After a trigger, at most 32 minus watermark samples are taken, then overflow is set.
// - Overflow and trigger arming clear only on full read-out or flush.
// - Trigger sources are within band, outside band and tilt change, each enabled.
// - With gate clear, a power state transition flushes the buffer.
// - With gate set, a transition while samples are held discards new samples, flags and counts them.
// - The gate error flag stays set until the buffer is emptied.
// - In trigger mode with a nonzero sleep delay count the gate bit is ignored.
module asbc_top (
  // Clock and reset.
  input wire core_clk,
  input wire resetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Sample stream.
  input wire sample_valid,
  input wire [`ASBC_SAMPLE_W-1:0] sample_data,
  // Detector and power state events.
  input wire evt_within_band,
  input wire evt_outside_band,
  input wire evt_tilt_change,
  input wire power_transition,
  // Interrupt.
  output reg irq
);
  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] buffer_collection_config;
  reg [5:0] watermark_level;
  reg sensor_active;
  reg second_pin_function;
  reg [7:0] sleep_delay_count;
  reg [4:0] wr_ptr;
  reg [5:0] count;
  reg [5:0] post_cnt;
  reg triggered;
  reg overflow_flag;
  reg gated;
  reg gate_error;
  reg [7:0] gate_discard_count;
  reg [`ASBC_IRQ_W-1:0] irq_stat;
  reg [`ASBC_IRQ_W-1:0] irq_en;
  reg [4:0] next_wr_ptr;
  reg [5:0] next_count;
  reg mem_we;
  reg [4:0] mem_waddr;
  reg accept;
  reg grow;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire [`ASBC_SAMPLE_W-1:0] head_data;
  wire trig_hit;

  // Bus decode helper.
  function hit;
    input [7:0] addr;
    input [5:0] idx;
    begin
      hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  // Watermark clamped to the buffer depth.
  function [5:0] wmrk_cap;
    input [5:0] w;
    begin
      wmrk_cap = (w > `ASBC_DEPTH) ? `ASBC_DEPTH : w;
    end
  endfunction

  wire [1:0] mode = buffer_collection_config[`ASBC_CFG_MODE_HI:`ASBC_CFG_MODE_LO];
  wire lifo = buffer_collection_config[`ASBC_CFG_ORDER];
  wire [5:0] wmrk = wmrk_cap(watermark_level);
  wire [5:0] post_limit = `ASBC_DEPTH - wmrk;
  wire xfer = psel & penable & pready;
  wire wr_xfer = xfer & pwrite;
  wire pop = xfer & ~pwrite & hit(paddr, `ASBC_IDX_DATA_Z) & (count != 6'h00);
  // A store in the same cycle as the last pop leaves the buffer occupied.
  wire emptied = pop & (count == 6'h01) & ~accept;
  wire sw_flush = wr_xfer & hit(paddr, `ASBC_IDX_CONFIG2) & pwdata[`ASBC_FLUSH_BIT];
  wire gate_on = buffer_collection_config[`ASBC_CFG_GATE] &
                 ~((mode == `ASBC_MODE_TRIG) && (sleep_delay_count != 8'h00));
  wire auto_flush = power_transition & ~gate_on;
  wire flush = sw_flush | auto_flush;
  wire cfg_locked = sensor_active | second_pin_function;
  wire [5:0] head_sum = {1'b0, wr_ptr} - (lifo ? 6'h01 : count);
  wire [4:0] head_idx = head_sum[4:0];
  wire trig_now = (mode == `ASBC_MODE_TRIG) & ~triggered & ~overflow_flag & trig_hit;
  wire discard = sample_valid & (gated | (power_transition & gate_on & (count != 6'h00)));
  wire ovf_set = (accept & triggered & (post_cnt + 6'h01 == post_limit)) |
                 (trig_now & (post_limit == 6'h00));

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source combination.
  asbc_trig_sel u_trig (
    .cfg(buffer_collection_config),
    .evt_within_band(evt_within_band),
    .evt_outside_band(evt_outside_band),
    .evt_tilt_change(evt_tilt_change),
    .trig_hit(trig_hit)
  );

  // Sample storage.
  asbc_sample_mem u_mem (
    .core_clk(core_clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(sample_data),
    .rd_addr(head_idx),
    .rd_data(head_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decide whether an arriving sample is stored and whether the fill grows.
  always @* begin
    accept = 1'b0;
    grow = 1'b0;
    if (sample_valid && !discard && !flush) begin
      case (mode)
        `ASBC_MODE_OFF: begin
          accept = 1'b0;
        end
        `ASBC_MODE_STREAM: begin
          accept = 1'b1;
          grow = (count != `ASBC_DEPTH) | pop;
        end
        `ASBC_MODE_STOP: begin
          accept = (count != `ASBC_DEPTH);
          grow = 1'b1;
        end
        `ASBC_MODE_TRIG: begin
          if (triggered) begin
            accept = ~overflow_flag & (post_cnt < post_limit);
            grow = 1'b1;
          end else begin
            accept = (wmrk != 6'h00);
            grow = (count < wmrk) | pop;
          end
        end
        default: begin
          accept = 1'b0;
        end
      endcase
    end
  end

  // Pointer and fill updates; a read and a store may share a cycle.
  always @* begin
    next_wr_ptr = wr_ptr;
    next_count = count;
    mem_we = 1'b0;
    mem_waddr = wr_ptr;
    if (pop) begin
      next_count = count - 6'h01;
      if (lifo) begin
        next_wr_ptr = wr_ptr - 5'h01;
      end
    end
    if (accept) begin
      mem_we = 1'b1;
      mem_waddr = next_wr_ptr;
      next_wr_ptr = next_wr_ptr + 5'h01;
      if (grow) begin
        next_count = next_count + 6'h01;
      end
    end
    if (flush) begin
      next_wr_ptr = 5'h00;
      next_count = 6'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer state, trigger arming, overflow and gating.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 5'h00;
      count <= 6'h00;
      post_cnt <= 6'h00;
      triggered <= 1'b0;
      overflow_flag <= 1'b0;
      gated <= 1'b0;
      gate_error <= 1'b0;
      gate_discard_count <= 8'h00;
    end else begin
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      if (flush || emptied) begin
        post_cnt <= 6'h00;
        triggered <= 1'b0;
        overflow_flag <= 1'b0;
        gated <= 1'b0;
        gate_error <= 1'b0;
        gate_discard_count <= 8'h00;
      end else begin
        if (trig_now) begin
          triggered <= 1'b1;
          post_cnt <= 6'h00;
        end else if (accept && triggered) begin
          post_cnt <= post_cnt + 6'h01;
        end
        if (ovf_set) begin
          overflow_flag <= 1'b1;
        end
        if (power_transition && gate_on && (count != 6'h00)) begin
          gated <= 1'b1;
        end
        if (discard) begin
          gate_error <= 1'b1;
          if (gate_discard_count != 8'hFF) begin
            gate_discard_count <= gate_discard_count + 8'h01;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; writes take effect at the completing edge.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      buffer_collection_config <= `ASBC_CFG_RESET;
      watermark_level <= 6'h00;
      sensor_active <= 1'b0;
      second_pin_function <= 1'b0;
      sleep_delay_count <= 8'h00;
      irq_en <= 3'h0;
    end else if (wr_xfer) begin
      if (hit(paddr, `ASBC_IDX_CONFIG1) && !cfg_locked) begin
        buffer_collection_config <= pwdata[7:0];
      end
      if (hit(paddr, `ASBC_IDX_CONFIG2)) begin
        watermark_level <= pwdata[`ASBC_WMRK_HI:0];
      end
      if (hit(paddr, `ASBC_IDX_CTRL)) begin
        sensor_active <= pwdata[`ASBC_CTRL_ACTIVE];
        second_pin_function <= pwdata[`ASBC_CTRL_PIN2];
        sleep_delay_count <= pwdata[`ASBC_CTRL_SLP_HI:`ASBC_CTRL_SLP_LO];
      end
      if (hit(paddr, `ASBC_IDX_IRQ_EN)) begin
        irq_en <= pwdata[`ASBC_IRQ_W-1:0];
      end
    end
  end

  // Sticky interrupt status; a new event wins over a clear in the same cycle.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_xfer && hit(paddr, `ASBC_IDX_IRQ_CLR)) ?
                  pwdata[`ASBC_IRQ_W-1:0] : 3'h0)) |
                  {trig_now, discard & ~gate_error, ovf_set & ~overflow_flag};
      irq <= |(irq_stat & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped addresses read zero and flag an error.
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (hit(paddr, `ASBC_IDX_CONFIG1)) begin
      rd_mux = {24'h00_0000, buffer_collection_config};
    end else if (hit(paddr, `ASBC_IDX_CONFIG2)) begin
      rd_mux = {26'h000_0000, watermark_level};
    end else if (hit(paddr, `ASBC_IDX_CTRL)) begin
      rd_mux = {16'h0000, sleep_delay_count, 6'h00, second_pin_function, sensor_active};
    end else if (hit(paddr, `ASBC_IDX_STATUS)) begin
      rd_mux = {8'h00, gate_discard_count, 7'h00, triggered, gate_error,
                overflow_flag, count};
    end else if (hit(paddr, `ASBC_IDX_DATA_XY)) begin
      rd_mux = (count != 6'h00) ? {8'h00, head_data[23:0]} : 32'h0000_0000;
    end else if (hit(paddr, `ASBC_IDX_DATA_Z)) begin
      rd_mux = (count != 6'h00) ? {20'h0_0000, head_data[35:24]} : 32'h0000_0000;
    end else if (hit(paddr, `ASBC_IDX_IRQ_STAT)) begin
      rd_mux = {29'h0000_0000, irq_stat};
    end else if (hit(paddr, `ASBC_IDX_IRQ_EN)) begin
      rd_mux = {29'h0000_0000, irq_en};
    end else if (hit(paddr, `ASBC_IDX_IRQ_CLR)) begin
      rd_mux = 32'h0000_0000;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // APB answer: one wait cycle, then pready for exactly one cycle.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~rd_hit;
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end
endmodule // asbc_top

// ### verification/asbc_top_props.sv
// Port checker for the sample buffer control block.
`timescale 1ns/1ps
`include "asbc_consts.vh"
module asbc_props (
  // Clock and reset.
  input wire core_clk,
  input wire resetn,
  // APB.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Interrupt.
  input wire irq
);
  // Aligned addresses inside and outside the register map.
  wire al = paddr[1:0] == 2'h0;
  wire inmap = paddr[7:2] >= `ASBC_IDX_CONFIG1 && paddr[7:2] <= `ASBC_IDX_IRQ_CLR;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  a_rdy_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_rdy_cause: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  a_rdy_time: assert property (psel && penable && !pready |=> pready) else $error("late pready");
  a_idle_quiet: assert property (!psel |=> !pready) else $error("pready while idle");
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  a_err_map: assert property (pready && al && !inmap |-> pslverr) else $error("no error");
  a_ok_map: assert property (pready && al && inmap |-> !pslverr) else $error("false error");
  a_rd_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  a_clr_zero: assert property (pready && !pwrite && paddr[7:2] == `ASBC_IDX_IRQ_CLR
    |-> prdata == 32'h0) else $error("clear register read nonzero");
  // Main scenarios reached.
  c_err: cover property (pslverr);
  c_read: cover property (pready && !pwrite);
  c_irq: cover property ($rose(irq));
endmodule // asbc_props
bind asbc_top asbc_props u_props (.core_clk(core_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

// ### verification/asbc_host.sv
// Host model driving the APB register port of the buffer block.
`timescale 1ns/1ps
`include "asbc_consts.vh"
module asbc_host (
  // Clock.
  input wire core_clk,
  // APB master.
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [7:0] paddr,
  output reg [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  reg [31:0] q;
  reg e;
  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One transfer; released lines show the inverse so stale data never matches.
  task xfer(input [5:0] i, input w, input [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      paddr <= {i, 2'h0};
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~{i, 2'h0};
      pwdata <= ~d;
    end
  endtask
  task cfg(input [7:0] c);
    begin
      xfer(`ASBC_IDX_CTRL, 1'b1, 32'h0);
      xfer(`ASBC_IDX_CONFIG1, 1'b1, {24'h0, c});
    end
  endtask
  task flush(input [5:0] wm);
    xfer(`ASBC_IDX_CONFIG2, 1'b1, {24'h0, 2'h2, wm});
  endtask
  // Reads one sample, position first, then the popping half.
  task pop(output [35:0] s);
    begin
      xfer(`ASBC_IDX_DATA_XY, 1'b0, 32'h0);
      s[23:0] = q[23:0];
      xfer(`ASBC_IDX_DATA_Z, 1'b0, 32'h0);
      s[35:24] = q[11:0];
    end
  endtask
endmodule // asbc_host

// ### verification/test_accel_sample_buffer_control.sv
// Self-checking testbench for the sample buffer control block.
`timescale 1ns/1ps
`include "asbc_consts.vh"
module test_accel_sample_buffer_control;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg sample_valid = 1'b0;
  reg [35:0] sample_data = 36'h0;
  reg [2:0] ev = 3'h0;
  reg power_transition = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, irq;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  integer err_count = 0;
  integer checks_done = 0;
  integer k, post;
  reg [31:0] rs = 32'h35;
  reg [35:0] q[$];
  reg [7:0] cfg, gcnt;
  reg [5:0] wm;
  reg ovf, trg, gated, slp;
  wire [1:0] mode = cfg[6:5];
  asbc_top dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data),
    .evt_within_band(ev[2]), .evt_outside_band(ev[1]), .evt_tilt_change(ev[0]),
    .power_transition(power_transition), .irq(irq));
  asbc_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Clock generator.
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic [31:0] xs();
    begin
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      xs = rs;
    end
  endfunction
  task chk(input [35:0] seen, input [35:0] exp, input string nm);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task clr;
    begin
      q.delete();
      {ovf, trg, gated, post, gcnt} = 0;
    end
  endtask
  // Reference buffer: stores one sample as the mode asks.
  task put(input [35:0] s);
    begin
      if (gated)
        gcnt = gcnt + 8'h01;
      else if (mode == 2'h1 || (mode == 2'h2 && q.size() < 32)) begin
        if (q.size() == 32)
          void'(q.pop_front());
        q.push_back(s);
      end else if (mode == 2'h3 && !trg) begin
        q.push_back(s);
        if (q.size() > wm)
          void'(q.pop_front());
      end else if (mode == 2'h3 && post < 32 - wm) begin
        q.push_back(s);
        post = post + 1;
        ovf = (post == 32 - wm);
      end
    end
  endtask
  task push(input integer n);
    reg [31:0] t;
    reg [35:0] s;
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        t = xs();
        s = {t[3:0], xs()};
        @(posedge core_clk);
        sample_valid <= 1'b1;
        sample_data <= s;
        put(s);
      end
      @(posedge core_clk);
      sample_valid <= 1'b0;
    end
  endtask
  task pops(input integer n);
    reg [35:0] s, e;
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        host.pop(s);
        if (q.size() == 0) e = 36'h0;
        else if (cfg[7]) e = q.pop_back();
        else e = q.pop_front();
        chk(s, e, "sample");
        if (q.size() == 0)
          clr;
      end
    end
  endtask
  task stchk;
    reg [5:0] n;
    begin
      n = 6'(q.size());
      host.xfer(`ASBC_IDX_STATUS, 1'b0, 32'h0);
      chk(host.q[15:0], {7'h0, trg, gcnt != 0, ovf, n}, "status");
      if (gcnt != 0)
        chk(host.q[23:16], gcnt, "gate count");
    end
  endtask
  task fire(input [2:0] src);
    begin
      @(posedge core_clk);
      ev <= src;
      if (mode == 2'h3 && (src & {cfg[3], cfg[2], cfg[0]}) != 3'h0)
        trg = 1'b1;
      @(posedge core_clk);
      ev <= 3'h0;
    end
  endtask
  task pwr;
    begin
      @(posedge core_clk);
      power_transition <= 1'b1;
      if (!cfg[4] || (mode == 2'h3 && slp))
        clr;
      else if (q.size() != 0)
        gated = 1'b1;
      @(posedge core_clk);
      power_transition <= 1'b0;
    end
  endtask
  task setc(input [7:0] c);
    begin
      host.cfg(c);
      cfg = c;
    end
  endtask
  task fl(input [5:0] w);
    begin
      host.flush(w);
      wm = w;
      clr;
    end
  endtask
  task final_report;
    begin
      if (err_count == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang; the tests need a few thousand cycles at most.
  initial begin
    #100000;
    err_count = err_count + 1;
    final_report;
  end
  // Main sequence.
  initial begin
    {cfg, wm, slp} = 0;
    clr;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    host.xfer(`ASBC_IDX_CONFIG1, 1'b0, 32'h0);
    chk(host.q, 32'h0, "cfg reset");
    setc(8'h02);
    host.xfer(`ASBC_IDX_CONFIG1, 1'b0, 32'h0);
    chk(host.q, 32'h2, "cfg spare");
    host.xfer(6'h30, 1'b0, 32'h0);
    chk(host.e, 1'b1, "unmapped");
    host.xfer(`ASBC_IDX_IRQ_EN, 1'b1, 32'h1);
    for (k = 1; k < 3; k = k + 1) begin
      host.xfer(`ASBC_IDX_CTRL, 1'b1, k);
      host.xfer(`ASBC_IDX_CONFIG1, 1'b1, 32'h20);
      host.xfer(`ASBC_IDX_CONFIG1, 1'b0, 32'h0);
      chk(host.q, 32'h2, "cfg locked");
    end
    setc(8'h02);
    push(3);
    stchk;
    setc(8'h20);
    push(35);
    stchk;
    pops(32);
    setc(8'hA0);
    push(3);
    pops(3);
    setc(8'h40);
    push(34);
    stchk;
    pops(32);
    for (k = 0; k < 3; k = k + 1) begin
      setc(8'h60 | (k == 0 ? 8'h08 : k == 1 ? 8'h04 : 8'h01));
      fl(4);
      push(6);
      fire(3'h4 >> ((k + 1) % 3));
      push(2);
      fire(3'h4 >> k);
      push(30);
      stchk;
      #1 chk(irq, 1'b1, "irq set");
      host.xfer(`ASBC_IDX_IRQ_STAT, 1'b0, 32'h0);
      chk(host.q[2:0], 3'h5, "irq status");
      host.xfer(`ASBC_IDX_IRQ_CLR, 1'b1, 32'h7);
      // The level output follows the cleared status one edge later.
      @(posedge core_clk);
      #1 chk(irq, 1'b0, "irq cleared");
      pops(32);
      stchk;
    end
    setc(8'h20);
    fl(0);
    push(3);
    pwr;
    stchk;
    setc(8'h30);
    push(2);
    pwr;
    push(3);
    stchk;
    #1 chk(irq, 1'b0, "irq masked");
    pops(2);
    stchk;
    setc(8'h70);
    host.xfer(`ASBC_IDX_CTRL, 1'b1, 32'h100);
    slp = 1'b1;
    fl(8);
    push(3);
    pwr;
    stchk;
    final_report;
  end
endmodule // test_accel_sample_buffer_control
